// *** hdl/spi_frame_shift.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_frame_shift (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// synchronised pins
	input  wire logic                 sclk_s,
	input  wire logic                 cs_b_s,
	input  wire logic                 mosi_s,
	// word to send next frame
	input  wire logic [15:0]          tx_word,
	// received frame
	output var  sync_ctrl_pkg::frame_t rx_frame,
	output var  logic                 frame_done,
	output var  logic                 miso
);
	import sync_ctrl_pkg::*;

	logic             sclk_d_r, sclk_d_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [15:0]      sh_r, sh_nxt;
	logic [15:0]      tx_r, tx_nxt;
	logic             miso_nxt;
	logic             done_nxt;
	frame_t           rx_nxt;
	logic             rise;
	logic             fall;

	always_comb begin
		rise       = sclk_s & ~sclk_d_r;
		fall       = ~sclk_s & sclk_d_r;
		sclk_d_nxt = sclk_s;
		cnt_nxt    = cnt_r;
		sh_nxt     = sh_r;
		tx_nxt     = tx_r;
		miso_nxt   = miso;
		done_nxt   = 1'b0;
		rx_nxt     = rx_frame;
		if (cs_b_s) begin
			// idle: keep the reply loaded so bit 15 is ready before the first edge
			cnt_nxt  = '0;
			tx_nxt   = tx_word;
			miso_nxt = tx_word[15];
		end else begin
			if (rise && cnt_r < CNT_W'(FRAME_BITS)) begin
				sh_nxt  = {sh_r[14:0], mosi_s};
				cnt_nxt = cnt_r + CNT_W'(1);
				// last rising edge completes the frame
				if (cnt_r == CNT_W'(FRAME_BITS - 1)) begin
					done_nxt = 1'b1;
					rx_nxt   = frame_t'({sh_r[14:0], mosi_s});
				end
			end
			if (fall && cnt_r < CNT_W'(FRAME_BITS)) begin
				tx_nxt   = {tx_r[14:0], 1'b0};
				miso_nxt = tx_r[14];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sclk_d_r   <= 1'b0;
			cnt_r      <= '0;
			sh_r       <= '0;
			tx_r       <= '0;
			miso       <= 1'b0;
			frame_done <= 1'b0;
			rx_frame   <= '0;
		end else begin
			sclk_d_r   <= sclk_d_nxt;
			cnt_r      <= cnt_nxt;
			sh_r       <= sh_nxt;
			tx_r       <= tx_nxt;
			miso       <= miso_nxt;
			frame_done <= done_nxt;
			rx_frame   <= rx_nxt;
		end
	end
endmodule
`default_nettype wire

// *** hdl/sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	// meta_r feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// *** hdl/sync_ctrl_pkg.sv ***
package sync_ctrl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// serial frame: rd flag, 7-bit register index, 8-bit data
	localparam int unsigned FRAME_BITS   = 16;
	localparam int unsigned CNT_W        = 5;

	typedef struct packed {
		logic       rd;
		logic [6:0] addr;
		logic [7:0] data;
	} frame_t;

	////////////////////////////////////////////////////////////////////////////////
	// control register map and layout
	localparam logic [6:0]  ADDR_CTRL      = 7'h06;
	localparam logic [7:0]  CTRL_RESET     = 8'h80;
	localparam logic [7:0]  CTRL_WMASK     = 8'h93;
	localparam int unsigned BIT_SW_SYNC    = 7;
	localparam int unsigned BIT_ONESHOT    = 4;
	localparam int unsigned RST_LSB        = 0;
	localparam logic [1:0]  RST_FIRST      = 2'h3;
	localparam logic [1:0]  RST_SECOND     = 2'h2;
	localparam logic [15:0] RESET_REPLY    = 16'h0e00;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam logic [15:0] SETTLE_DEFAULT = 16'h0400;

	typedef enum logic [0:0] {
		RST_IDLE,
		RST_ARMED
	} rst_state_t;

endpackage

// *** hdl/sync_reset_oneshot_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - sync command recognised at last rising serial clock of the low-to-high write
// - recognised sync goes out on sync output aligned to master clock
// - software sync acts exactly like a pulse on the start pin
// - every sync input pulse resets the digital filters
// - conversion data withheld until filter settling time has elapsed
// - one-shot enabled: one conversion result when settling ends after the last sync input rising edge
// - soft reset only on code 3 then code 2; codes 0 and 1 cancel an armed code 3
// - completed soft reset resets core and returns registers to defaults
// - after soft reset, first command is answered next frame with 0x0e00
// - control register resets to 0x80: sync high, one-shot and reset zero
module sync_reset_oneshot_control #(
	parameter logic [15:0] SETTLE_CYCLES = sync_ctrl_pkg::SETTLE_DEFAULT
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// serial register port
	input  wire logic sclk,
	input  wire logic cs_b,
	input  wire logic mosi,
	output var  logic miso,
	// master clock and sync pins
	input  wire logic mclk,
	input  wire logic start_b,
	input  wire logic sync_in,
	output var  logic sync_out,
	// to the converter core
	output var  logic filter_reset,
	output var  logic data_hold,
	output var  logic oneshot_req,
	output var  logic oneshot_en,
	output var  logic core_reset
);
	import sync_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic       sclk_s;
	logic       cs_b_s;
	logic       mosi_s;
	logic       mclk_s;
	logic       start_b_s;
	logic       sync_in_s;
	frame_t     rx_frame;
	logic       frame_done;

	sync2 #(
		.W (6)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.async_in ({sclk, cs_b, mosi, mclk, start_b, sync_in}),
		.sync_out ({sclk_s, cs_b_s, mosi_s, mclk_s, start_b_s, sync_in_s})
	);

	logic [15:0] tx_word_r, tx_word_nxt;

	spi_frame_shift u_spi (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.sclk_s     (sclk_s),
		.cs_b_s     (cs_b_s),
		.mosi_s     (mosi_s),
		.tx_word    (tx_word_r),
		.rx_frame   (rx_frame),
		.frame_done (frame_done),
		.miso       (miso)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin edge detectors
	logic mclk_d_r, mclk_d_nxt;
	logic start_d_r, start_d_nxt;
	logic sync_in_d_r, sync_in_d_nxt;
	logic mclk_rise;
	logic start_fall;
	logic sync_rise;

	// mclk is only sampled: high or low phases shorter than one cycle can be lost
	always_comb begin
		mclk_d_nxt    = mclk_s;
		start_d_nxt   = start_b_s;
		sync_in_d_nxt = sync_in_s;
		mclk_rise     = mclk_s & ~mclk_d_r;
		start_fall    = start_d_r & ~start_b_s;
		sync_rise     = sync_in_s & ~sync_in_d_r;
	end

	// start history resets low like its synchroniser, so no false fall after reset
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			mclk_d_r    <= 1'b0;
			start_d_r   <= 1'b0;
			sync_in_d_r <= 1'b0;
		end else begin
			mclk_d_r    <= mclk_d_nxt;
			start_d_r   <= start_d_nxt;
			sync_in_d_r <= sync_in_d_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register file and soft reset sequencer
	logic [7:0]  ctrl_r, ctrl_nxt;
	rst_state_t  rst_st_r, rst_st_nxt;
	logic        reply_pend_r, reply_pend_nxt;
	logic        sw_sync_r, sw_sync_nxt;
	logic        core_reset_nxt;
	logic        wr_ctrl;
	logic        soft_rst;
	logic [7:0]  rdata;

	// only a complete write frame to the control address counts
	always_comb begin
		wr_ctrl = frame_done & ~rx_frame.rd & (rx_frame.addr == ADDR_CTRL);
		rdata   = (rx_frame.addr == ADDR_CTRL) ? ctrl_r : 8'h00;
	end

	// soft reset sequencer; reads and other addresses leave it armed
	always_comb begin
		rst_st_nxt     = rst_st_r;
		core_reset_nxt = 1'b0;
		soft_rst       = 1'b0;
		if (wr_ctrl) begin
			case (rx_frame.data[RST_LSB +: 2])
				RST_FIRST: rst_st_nxt = RST_ARMED;
				RST_SECOND: begin
					// second code only counts straight after the first
					if (rst_st_r == RST_ARMED) begin
						soft_rst       = 1'b1;
						core_reset_nxt = 1'b1;
					end
					rst_st_nxt = RST_IDLE;
				end
				default: rst_st_nxt = RST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rst_st_r   <= RST_IDLE;
			core_reset <= 1'b0;
		end else begin
			rst_st_r   <= rst_st_nxt;
			core_reset <= core_reset_nxt;
		end
	end

	// control register and software sync detect
	always_comb begin
		ctrl_nxt    = ctrl_r;
		sw_sync_nxt = 1'b0;
		if (wr_ctrl) begin
			ctrl_nxt = rx_frame.data & CTRL_WMASK;
			// low-to-high change of the software sync bit, at frame end
			if (!ctrl_r[BIT_SW_SYNC] && rx_frame.data[BIT_SW_SYNC]) begin
				sw_sync_nxt = 1'b1;
			end
		end
		// the reset wins over the write that completes it, pending sync included
		if (soft_rst) begin
			ctrl_nxt    = CTRL_RESET;
			sw_sync_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ctrl_r    <= CTRL_RESET;
			sw_sync_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			sw_sync_r <= sw_sync_nxt;
		end
	end

	// reply word, shifted out during the following frame
	always_comb begin
		reply_pend_nxt = reply_pend_r;
		tx_word_nxt    = tx_word_r;
		if (frame_done) begin
			tx_word_nxt    = reply_pend_r ? RESET_REPLY : {rx_frame.rd, rx_frame.addr, rdata};
			reply_pend_nxt = 1'b0;
		end
		if (soft_rst) begin
			reply_pend_nxt = 1'b1;
			tx_word_nxt    = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			reply_pend_r <= 1'b0;
			tx_word_r    <= '0;
		end else begin
			reply_pend_r <= reply_pend_nxt;
			tx_word_r    <= tx_word_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sync output, one master clock period wide
	logic sync_pend_r, sync_pend_nxt;
	logic sync_out_nxt;

	always_comb begin
		sync_pend_nxt = sync_pend_r;
		sync_out_nxt  = sync_out;
		// software sync and start pin share one path
		if (sw_sync_r || start_fall) begin
			sync_pend_nxt = 1'b1;
		end
		if (mclk_rise) begin
			if (sync_out) begin
				sync_out_nxt = 1'b0;
			end else if (sync_pend_r) begin
				sync_out_nxt  = 1'b1;
				sync_pend_nxt = 1'b0;
			end
		end
		if (core_reset) begin
			sync_pend_nxt = 1'b0;
			sync_out_nxt  = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sync_pend_r <= 1'b0;
			sync_out    <= 1'b0;
		end else begin
			sync_pend_r <= sync_pend_nxt;
			sync_out    <= sync_out_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// filter reset, settling and one-shot
	logic [15:0] settle_r, settle_nxt;
	logic        armed_r, armed_nxt;
	logic        filter_reset_nxt;
	logic        data_hold_nxt;
	logic        oneshot_req_nxt;
	logic        oneshot_en_nxt;

	always_comb begin
		settle_nxt       = settle_r;
		armed_nxt        = armed_r;
		filter_reset_nxt = 1'b0;
		data_hold_nxt    = data_hold;
		oneshot_req_nxt  = 1'b0;
		oneshot_en_nxt   = ctrl_nxt[BIT_ONESHOT];
		if (sync_rise) begin
			// any rising sync edge restarts settling, also mid-settle
			filter_reset_nxt = 1'b1;
			settle_nxt       = SETTLE_CYCLES;
			data_hold_nxt    = 1'b1;
			armed_nxt        = ctrl_r[BIT_ONESHOT];
		end else if (settle_r != 16'h0000) begin
			settle_nxt = settle_r - 16'h0001;
			if (settle_r == 16'h0001) begin
				data_hold_nxt   = 1'b0;
				oneshot_req_nxt = armed_r;
				armed_nxt       = 1'b0;
			end
		end
		if (core_reset) begin
			settle_nxt    = '0;
			armed_nxt     = 1'b0;
			data_hold_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			settle_r     <= '0;
			armed_r      <= 1'b0;
			filter_reset <= 1'b0;
			data_hold    <= 1'b0;
			oneshot_req  <= 1'b0;
			oneshot_en   <= 1'b0;
		end else begin
			settle_r     <= settle_nxt;
			armed_r      <= armed_nxt;
			filter_reset <= filter_reset_nxt;
			data_hold    <= data_hold_nxt;
			oneshot_req  <= oneshot_req_nxt;
			oneshot_en   <= oneshot_en_nxt;
		end
	end
endmodule
`default_nettype wire

// *** verification/spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// serial pins
	output var  logic sclk,
	output var  logic cs_b,
	output var  logic mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		mosi = 1'b0;
	end
	// mode 0, msb first, 32 ns clock; gap sets how slow the host is
	task automatic xfer(input logic [15:0] tx, input int gap, output logic [15:0] rx);
		cs_b = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = tx[i];
			#16 sclk = 1'b1;
			rx[i] = miso;
			#16 sclk = 1'b0;
		end
		// released line must not keep a plausible value
		mosi = ~mosi;
		#16 cs_b = 1'b1;
		#(gap);
	endtask
endmodule
`default_nettype wire

// *** verification/sync_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_ctrl_assertions #(
	parameter logic [15:0] SETTLE_CYCLES = sync_ctrl_pkg::SETTLE_DEFAULT
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// sync pins and core outputs
	input  wire logic sync_in,
	input  wire logic sync_out,
	input  wire logic filter_reset,
	input  wire logic data_hold,
	input  wire logic oneshot_req,
	input  wire logic oneshot_en,
	input  wire logic core_reset
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////
	// cycles since the last filter reset
	logic [15:0] held_r;
	logic [15:0] held_nxt;
	always_comb held_nxt = filter_reset ? 16'h0001 : held_r + 16'h0001;
	always_ff @(posedge sys_clk) held_r <= held_nxt;
	////////////////////////////////////////////////
	filt_pulse_a: assert property (filter_reset |=> !filter_reset)
		else $error("filter reset too long");
	filt_cause_a: assert property ($rose(sync_in) |-> ##[1:4] filter_reset)
		else $error("sync edge gave no filter reset");
	hold_start_a: assert property (filter_reset |-> data_hold)
		else $error("data not withheld at filter reset");
	hold_len_a: assert property ($fell(data_hold) |-> held_r == SETTLE_CYCLES)
		else $error("settling time wrong");
	shot_end_a: assert property (oneshot_req |-> $fell(data_hold))
		else $error("one-shot result outside settle end");
	shot_mode_a: assert property (oneshot_req |-> oneshot_en)
		else $error("one-shot result while disabled");
	sync_width_a: assert property ($rose(sync_out) |=> sync_out[*8] ##[1:8] !sync_out)
		else $error("sync output width wrong");
	core_pulse_a: assert property (core_reset |=> !core_reset)
		else $error("core reset too long");
	core_clear_a: assert property (core_reset |-> ##2 !oneshot_en && !data_hold)
		else $error("soft reset left state behind");
	sync_c: cover property ($rose(sync_out));
	shot_c: cover property (oneshot_req);
	core_c: cover property (core_reset);
endmodule
bind sync_reset_oneshot_control sync_ctrl_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (
	.sys_clk(sys_clk), .rst_b(rst_b), .sync_in(sync_in), .sync_out(sync_out),
	.filter_reset(filter_reset), .data_hold(data_hold), .oneshot_req(oneshot_req),
	.oneshot_en(oneshot_en), .core_reset(core_reset));
`default_nettype wire

// *** verification/sync_reset_oneshot_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_reset_oneshot_control_tb;
	import sync_ctrl_pkg::*;
	logic        sys_clk, rst_b, mclk, start_b, ext_sync, so_q;
	logic [15:0] n_sync, n_filt, n_shot, n_core, rx_w;
	int          checked, miscompares;
	wire logic   sclk, cs_b, mosi, miso, sync_in, sync_out;
	wire logic   filter_reset, data_hold, oneshot_req, oneshot_en, core_reset;
	// board loop of sync output back to sync input
	assign sync_in = sync_out | ext_sync;
	sync_reset_oneshot_control #(.SETTLE_CYCLES(16'h0010)) dut_u (
		.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .mosi(mosi),
		.miso(miso), .mclk(mclk), .start_b(start_b), .sync_in(sync_in),
		.sync_out(sync_out), .filter_reset(filter_reset), .data_hold(data_hold),
		.oneshot_req(oneshot_req), .oneshot_en(oneshot_en), .core_reset(core_reset));
	spi_host_model host_u (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// offset keeps master clock edges away from sampling edges
	initial begin
		mclk = 1'b0;
		#1;
		forever #24 mclk = ~mclk;
	end
	////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		so_q <= sync_out;
		if (rst_b == 1'b0) begin
			{n_sync, n_filt, n_shot, n_core} <= 64'h0;
		end else begin
			n_sync <= n_sync + {15'h0, sync_out & ~so_q};
			n_filt <= n_filt + {15'h0, filter_reset};
			n_shot <= n_shot + {15'h0, oneshot_req};
			n_core <= n_core + {15'h0, core_reset};
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic fr(input logic [15:0] w);
		@(posedge sys_clk);
		#1;
		host_u.xfer(w, 200, rx_w);
	endtask
	// reply of a read shows in the frame after it
	task automatic rdchk(input logic [6:0] a, input logic [7:0] d);
		fr({1'b1, a, 8'h00});
		fr({1'b1, a, 8'h00});
		check(rx_w, {1'b1, a, d});
	endtask
	task automatic quiet;
		repeat (120) @(posedge sys_clk);
	endtask
	task automatic pin_pulse(input logic is_start);
		@(posedge sys_clk);
		#1;
		if (is_start) start_b = 1'b0; else ext_sync = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		start_b = 1'b1;
		ext_sync = 1'b0;
		if (!is_start) begin
			check({15'h0, data_hold}, 16'h0001);
		end
		quiet;
		check({15'h0, data_hold}, 16'h0000);
	endtask
	////////////////////////////////////////////////
	initial begin
		{rst_b, start_b, ext_sync, checked, miscompares} = {1'b0, 1'b1, 1'b0, 64'h0};
		repeat (4) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		rdchk(ADDR_CTRL, CTRL_RESET);
		rdchk(7'h0b, 8'h00);
		fr(16'h0600);
		fr(16'h0680);
		quiet;
		check(n_sync, 16'h0001);
		check(n_filt, 16'h0001);
		fr(16'h0680);
		quiet;
		check(n_sync, 16'h0001);
		pin_pulse(1'b1);
		check(n_filt, 16'h0002);
		for (int i = 0; i < 2; i++) begin
			fr(16'h0600);
			fr(16'h0680);
			quiet;
		end
		check(n_sync, 16'h0004);
		fr(16'h0690);
		check({15'h0, oneshot_en}, 16'h0001);
		pin_pulse(1'b0);
		check(n_shot, 16'h0001);
		check(n_filt, 16'h0005);
		for (int c = 0; c < 2; c++) begin
			fr(16'h0603);
			fr({14'h0180, c[1:0]});
			fr(16'h0602);
		end
		quiet;
		check(n_core, 16'h0000);
		fr(16'h0613);
		fr(16'h8b00);
		fr(16'h0612);
		quiet;
		check(n_core, 16'h0001);
		check({15'h0, oneshot_en}, 16'h0000);
		fr(16'h8600);
		fr(16'h8600);
		check(rx_w, RESET_REPLY);
		fr(16'h8600);
		check(rx_w, 16'h8680);
		final_report;
	end
endmodule
`default_nettype wire
